// [verilog/psb_burst_averager.sv]
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Contract
// - Sample rate selectable from 8 to 4096 samples per second.
// - Paired-exposure option: two exposures per slot, averaged into one.
// - Average 1 to 128 samples; output rate is rate over count.
// - Four integration times: 14.8, 29.4, 58.7, 117.3 us by 2-bit code.
// - Burst off: conversions run continuously at the sample interval.
// - Burst on: conversions at the sample interval, count equals averaging count.
// - One averaged result per burst; bursts at 8, 32, 84 or 256 Hz.
// - Unsupported count up to 128 rounds up to the next supported count; counts above 128 give 128.
// - Burst too long for its period: burst enable clears, run continuous.
module psb_burst_averager
  import psb_pkg::*;
#(
  parameter int SMP_BASE_CYC = SMP_BASE_CYC_DFLT,
  parameter int INT3_CYC     = INT_CYC3_DFLT,
  parameter int BURST_CYC0   = CLK_HZ / BURST_HZ0,
  parameter int BURST_CYC1   = CLK_HZ / BURST_HZ1,
  parameter int BURST_CYC2   = CLK_HZ / BURST_HZ2,
  parameter int BURST_CYC3   = CLK_HZ / BURST_HZ3
) (
  input  wire logic        clk_i,           // System clock
  input  wire logic        rst_i,           // Async reset, high
  input  wire logic        s_axi_awvalid_i, // Write address valid
  output logic             s_axi_awready_o, // Write address ready
  input  wire logic [31:0] s_axi_awaddr_i,  // Write address
  input  wire logic        s_axi_wvalid_i,  // Write data valid
  output logic             s_axi_wready_o,  // Write data ready
  input  wire logic [31:0] s_axi_wdata_i,   // Write data
  input  wire logic [3:0]  s_axi_wstrb_i,   // Write byte enables
  output logic             s_axi_bvalid_o,  // Write response valid
  input  wire logic        s_axi_bready_i,  // Write response ready
  output logic [1:0]       s_axi_bresp_o,   // Write response
  input  wire logic        s_axi_arvalid_i, // Read address valid
  output logic             s_axi_arready_o, // Read address ready
  input  wire logic [31:0] s_axi_araddr_i,  // Read address
  output logic             s_axi_rvalid_o,  // Read data valid
  input  wire logic        s_axi_rready_i,  // Read data ready
  output logic [31:0]      s_axi_rdata_o,   // Read data
  output logic [1:0]       s_axi_rresp_o,   // Read response
  output logic             led_expose_o,    // LED on, integrating
  output logic             adc_start_o,     // Start of conversion pulse
  input  wire psb_sample_t adc_i,           // Conversion result
  output psb_sample_t      result_o         // Averaged result, strobed
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CTRL_W-1:0]      ctrl;
    logic [7:0]             avg;
    logic                   fallback;
    logic [31:0]            slot_cnt;
    logic [31:0]            burst_cnt;
    logic                   burst_act;
    logic [7:0]             done;
    logic                   half;
    psb_phase_t             phase;
    logic [31:0]            ph_cnt;
    logic [ACC_W-1:0]       acc;
    logic                   expose;
    logic                   adc_start;
    psb_sample_t            result;
    logic [1:0][ADC_W-1:0]  fifo;
    logic [1:0]             fcnt;
    logic                   wptr;
    logic                   rptr;
    logic                   awready;
    logic                   wready;
    logic                   aw_held;
    logic                   w_held;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } psb_state_t;

  psb_state_t s_q;
  psb_state_t s_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Only powers of two are averaged, so shifts replace the divide
  function automatic logic [2:0] avg_shift(input logic [7:0] n);
    logic [2:0] k;
    k = 3'h7;
    for (int i = 6; i >= 0; i--) begin
      if (n <= 8'(1 << i)) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  function automatic logic [31:0] sr_period(input logic [3:0] code);
    logic [3:0] c;
    c = (code > SR_MAX_CODE) ? SR_MAX_CODE : code;
    return 32'(SMP_BASE_CYC) << (SR_MAX_CODE - c);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return m;
  endfunction

  logic [2:0]       n_shift;
  logic [8:0]       n_eff;
  logic [31:0]      per_sample;
  logic [31:0]      per_burst;
  logic [31:0]      per_int;
  logic [40:0]      need;
  logic             too_slow;
  logic             slot_tick;
  logic             burst_tick;
  logic             can_start;
  logic             conv_done;
  logic             push;
  logic             pop;
  logic [ACC_W-1:0] acc_new;
  logic [31:0]      ctrl_w;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.adc_start = 1'b0;
    s_d.result.valid = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    acc_new = s_q.acc;
    ctrl_w = 32'h0;

    n_shift = avg_shift(s_q.avg);
    n_eff = 9'h1 << n_shift;
    per_sample = sr_period(s_q.ctrl[CTRL_SR_LSB +: 4]);
    case (s_q.ctrl[CTRL_BR_LSB +: 2])
      2'h0:    per_burst = 32'(BURST_CYC0);
      2'h1:    per_burst = 32'(BURST_CYC1);
      2'h2:    per_burst = 32'(BURST_CYC2);
      default: per_burst = 32'(BURST_CYC3);
    endcase
    case (s_q.ctrl[CTRL_INT_LSB +: 2])
      2'h0:    per_int = 32'(INT_CYC0);
      2'h1:    per_int = 32'(INT_CYC1);
      2'h2:    per_int = 32'(INT_CYC2);
      default: per_int = 32'(INT3_CYC);
    endcase
    need = 41'(n_eff) * 41'(per_sample);
    too_slow = s_q.ctrl[CTRL_BURST_BIT] && (need > 41'(per_burst));

    // Free-running slot and burst timers; a count beyond a newly shortened
    // period is cut back, or the old slow rate would linger for a period
    slot_tick = (s_q.slot_cnt == 32'h0);
    s_d.slot_cnt = (slot_tick || s_q.slot_cnt >= per_sample) ?
                   per_sample - 32'h1 : s_q.slot_cnt - 32'h1;
    burst_tick = (s_q.burst_cnt == 32'h0);
    s_d.burst_cnt = (burst_tick || s_q.burst_cnt >= per_burst) ?
                    per_burst - 32'h1 : s_q.burst_cnt - 32'h1;
    if (burst_tick && s_q.ctrl[CTRL_BURST_BIT]) begin
      s_d.burst_act = 1'b1;
    end

    // A full buffer holds off new slots so no result is ever dropped
    can_start = s_q.ctrl[CTRL_RUN_BIT] && (s_q.phase == PH_IDLE) &&
                (s_q.fcnt != 2'h2) &&
                (!s_q.ctrl[CTRL_BURST_BIT] || s_q.burst_act);
    conv_done = 1'b0;
    case (s_q.phase)
      PH_IDLE: begin
        if (slot_tick && can_start) begin
          s_d.phase = PH_EXPOSE;
          s_d.expose = 1'b1;
          s_d.ph_cnt = per_int - 32'h1;
          s_d.half = 1'b0;
        end
      end
      PH_EXPOSE: begin
        s_d.ph_cnt = s_q.ph_cnt - 32'h1;
        if (s_q.ph_cnt == 32'h0) begin
          s_d.expose = 1'b0;
          s_d.adc_start = 1'b1;
          s_d.phase = PH_CONVERT;
        end
      end
      PH_CONVERT: begin
        if (adc_i.valid) begin
          acc_new = s_q.acc + ACC_W'(adc_i.data);
          s_d.acc = acc_new;
          if (s_q.ctrl[CTRL_DUAL_BIT] && !s_q.half) begin
            s_d.half = 1'b1;
            s_d.phase = PH_EXPOSE;
            s_d.expose = 1'b1;
            s_d.ph_cnt = per_int - 32'h1;
          end else begin
            conv_done = 1'b1;
            s_d.phase = PH_IDLE;
          end
        end
      end
      default: s_d.phase = PH_IDLE;
    endcase

    if (conv_done) begin
      s_d.done = s_q.done + 8'h1;
      if (9'(s_q.done) + 9'h1 >= n_eff) begin
        push = 1'b1;
        s_d.done = 8'h0;
        s_d.acc = '0;
        // A burst tick landing on the closing push still opens a burst
        s_d.burst_act = burst_tick && s_q.ctrl[CTRL_BURST_BIT];
        s_d.result.valid = 1'b1;
        s_d.result.data = ADC_W'(acc_new >>
                          (4'(n_shift) + 4'(s_q.ctrl[CTRL_DUAL_BIT])));
        s_d.fifo[s_q.wptr] = s_d.result.data;
        s_d.wptr = ~s_q.wptr;
      end
    end

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid_i && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr_i[7:0];
    end
    if (s_axi_wvalid_i && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (s_q.awaddr == OFF_CTRL) begin
        ctrl_w = merge(32'(s_q.ctrl), s_q.wdata, s_q.wstrb);
        s_d.ctrl = ctrl_w[CTRL_W-1:0];
      end else if (s_q.awaddr == OFF_AVG) begin
        if (s_q.wstrb[0]) begin
          s_d.avg = s_q.wdata[7:0];
        end
      end else if (s_q.awaddr == OFF_STATUS) begin
        if (s_q.wstrb[0] && s_q.wdata[STAT_FALL_BIT]) begin
          s_d.fallback = 1'b0;
        end
      end else if (s_q.awaddr == OFF_DATA) begin
        s_d.bresp = RESP_OKAY;
      end else begin
        s_d.bresp = RESP_DECERR;
      end
    end
    // Hardware fallback wins over a software write in the same cycle
    if (too_slow) begin
      s_d.ctrl[CTRL_BURST_BIT] = 1'b0;
      s_d.fallback = 1'b1;
    end
    if (!s_d.ctrl[CTRL_BURST_BIT]) begin
      s_d.burst_act = 1'b0;
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;

    // AXI4-Lite read; reading the data word pops the buffer
    if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_axi_arvalid_i && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      if (s_axi_araddr_i[7:0] == OFF_CTRL) begin
        s_d.rdata = 32'(s_q.ctrl);
      end else if (s_axi_araddr_i[7:0] == OFF_AVG) begin
        s_d.rdata = 32'(s_q.avg);
      end else if (s_axi_araddr_i[7:0] == OFF_STATUS) begin
        s_d.rdata[STAT_FALL_BIT] = s_q.fallback;
        s_d.rdata[STAT_LVL_LSB +: 2] = s_q.fcnt;
        s_d.rdata[STAT_BUSY_BIT] = (s_q.phase != PH_IDLE);
      end else if (s_axi_araddr_i[7:0] == OFF_DATA) begin
        if (s_q.fcnt != 2'h0) begin
          pop = 1'b1;
          s_d.rdata[DATA_VLD_BIT] = 1'b1;
          s_d.rdata[ADC_W-1:0] = s_q.fifo[s_q.rptr];
          s_d.rptr = ~s_q.rptr;
        end
      end else begin
        s_d.rresp = RESP_DECERR;
      end
    end
    case ({push, pop})
      2'b10:   s_d.fcnt = s_q.fcnt + 2'h1;
      2'b01:   s_d.fcnt = s_q.fcnt - 2'h1;
      default: s_d.fcnt = s_q.fcnt;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.avg <= AVG_RST;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o  = s_q.wready;
  assign s_axi_bvalid_o  = s_q.bvalid;
  assign s_axi_bresp_o   = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o  = s_q.rvalid;
  assign s_axi_rdata_o   = s_q.rdata;
  assign s_axi_rresp_o   = s_q.rresp;
  assign led_expose_o    = s_q.expose;
  assign adc_start_o     = s_q.adc_start;
  assign result_o        = s_q.result;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [31:0] exp_len_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_len_q <= 32'h0;
    end else begin
      exp_len_q <= s_q.expose ? exp_len_q + 32'h1 : 32'h0;
    end
  end

  slot_period_a: assert property (slot_tick |=>
    s_q.slot_cnt == $past(per_sample) - 32'h1)
    else $error("slot timer reload wrong");
  dual_pair_a: assert property ((s_q.phase == PH_CONVERT &&
    adc_i.valid && s_q.ctrl[CTRL_DUAL_BIT] && !s_q.half) |=>
    s_q.expose && s_q.half && !result_o.valid)
    else $error("second exposure missing");
  avg_count_a: assert property (push |->
    9'(s_q.done) + 9'h1 == n_eff)
    else $error("result after wrong count");
  int_time_a: assert property ($fell(s_q.expose) |->
    exp_len_q == $past(per_int))
    else $error("integration time wrong");
  cont_run_a: assert property ((slot_tick && can_start &&
    !s_q.ctrl[CTRL_BURST_BIT]) |=> led_expose_o)
    else $error("continuous slot not started");
  burst_gate_a: assert property ((s_q.ctrl[CTRL_BURST_BIT] &&
    !s_q.burst_act) |=> !$rose(led_expose_o))
    else $error("conversion outside burst");
  burst_end_a: assert property ((push &&
    s_q.ctrl[CTRL_BURST_BIT] && !burst_tick) |=> !s_q.burst_act)
    else $error("burst not closed after result");
  round_up_a: assert property (s_q.avg inside {[8'h1:8'h80]} |->
    (n_eff >= 9'(s_q.avg)) && (n_eff < 9'(s_q.avg) * 9'h2))
    else $error("count not rounded up");
  fallback_a: assert property (too_slow |=>
    !s_q.ctrl[CTRL_BURST_BIT] && s_q.fallback)
    else $error("burst fallback missing");
  one_strobe_a: assert property (result_o.valid |=>
    !result_o.valid)
    else $error("strobe longer than one cycle");

  burst_push_c: cover property (push && s_q.ctrl[CTRL_BURST_BIT]);
  dual_push_c: cover property (push && s_q.ctrl[CTRL_DUAL_BIT]);
  fallback_c: cover property (too_slow);
  buf_full_c: cover property (s_q.fcnt == 2'h2 && slot_tick);

endmodule

// [verilog/psb_pkg.sv]
package psb_pkg;

  // ****************************************************************
  // Widths and register map
  // ****************************************************************
  localparam int ADC_W = 20;
  localparam int ACC_W = ADC_W + 9;
  localparam int CTRL_W = 11;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_AVG    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA   = 8'h0c;

  localparam int CTRL_BURST_BIT = 0;
  localparam int CTRL_DUAL_BIT  = 1;
  localparam int CTRL_INT_LSB   = 2;
  localparam int CTRL_SR_LSB    = 4;
  localparam int CTRL_BR_LSB    = 8;
  localparam int CTRL_RUN_BIT   = 10;
  localparam int STAT_FALL_BIT  = 0;
  localparam int STAT_LVL_LSB   = 1;
  localparam int STAT_BUSY_BIT  = 3;
  localparam int DATA_VLD_BIT   = 31;

  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [7:0]        AVG_RST  = 8'h01;
  localparam logic [3:0]        SR_MAX_CODE = 4'h9;
  localparam logic [1:0]        RESP_OKAY   = 2'b00;
  localparam logic [1:0]        RESP_DECERR = 2'b11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 20;
  localparam int CLK_HZ = 1_000_000_000 / CLK_NS;
  localparam int SR_MAX_HZ = 4096;
  localparam int SMP_BASE_CYC_DFLT = CLK_HZ / SR_MAX_HZ;
  // Integration times in tenths of a microsecond
  localparam int INT_T0_TUS = 148;
  localparam int INT_T1_TUS = 294;
  localparam int INT_T2_TUS = 587;
  localparam int INT_T3_TUS = 1173;
  localparam int INT_CYC0 = INT_T0_TUS * 100 / CLK_NS;
  localparam int INT_CYC1 = INT_T1_TUS * 100 / CLK_NS;
  localparam int INT_CYC2 = INT_T2_TUS * 100 / CLK_NS;
  localparam int INT_CYC3_DFLT = INT_T3_TUS * 100 / CLK_NS;
  localparam int BURST_HZ0 = 8;
  localparam int BURST_HZ1 = 32;
  localparam int BURST_HZ2 = 84;
  localparam int BURST_HZ3 = 256;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_EXPOSE  = 2'b01,
    PH_CONVERT = 2'b10
  } psb_phase_t;

  typedef struct packed {
    logic             valid;
    logic [ADC_W-1:0] data;
  } psb_sample_t;

endpackage

// [sim/psb_adc_model.sv]
`timescale 1ns/1ps
module psb_adc_model
  import psb_pkg::*;
(
  input  wire logic  clk_i,       // System clock
  input  wire logic  rst_i,       // Async reset, high
  input  wire logic  adc_start_i, // Start of conversion
  output psb_sample_t adc_o       // Conversion result
);
  // ****************************************************************
  // Converter answering after a random delay of 1 to 6 cycles
  // ****************************************************************
  integer      seed   = 32'h2c5e9a13;
  int          wait_n = 0;
  logic        busy   = 1'b0;
  logic [31:0] rnd;

  initial adc_o = '0;

  always @(posedge clk_i or posedge rst_i) begin
    rnd = $random(seed);
    if (rst_i) begin
      adc_o <= '0;
      busy  <= 1'b0;
    end else if (busy && wait_n == 0) begin
      adc_o <= {1'b1, rnd[ADC_W-1:0]};
      busy  <= 1'b0;
    end else begin
      // Word toggles between results so a stale value is never reused
      adc_o  <= {1'b0, ~adc_o.data};
      wait_n <= busy ? wait_n - 1 : int'(rnd[2:0] % 3'd6);
      busy   <= busy | adc_start_i;
    end
  end
endmodule

// [sim/test_ppg_sample_burst_averager.sv]
`timescale 1ns/1ps
module test_ppg_sample_burst_averager
  import psb_pkg::*;
;
  // ****************************************************************
  // Bench state
  // ****************************************************************
  localparam int SMP   = 64;
  localparam int INT3  = 20;
  localparam int BR3   = 640;
  localparam int LIMIT = 100000;

  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0;
  logic             rre = 1'b0, pair = 1'b0, led_p = 1'b0, res_p = 1'b0;
  logic             awr, wrdy, bv, arr, rv, led, start;
  logic [3:0]       strb = 4'hf;
  logic [31:0]      awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic [1:0]       bresp, rresp, last_resp;
  psb_sample_t      adc, res;
  integer           seed;
  int               compares = 0, n_fail = 0, cyc = 0, elen = 0;
  int               avg_n = 1, m, sum, nr, cnt;
  logic [ADC_W-1:0] got_q[$], smp_q[$];
  int               rise_q[$], len_q[$], res_t[$];
  int               k_tab[3] = '{9, 8, 15};
  int               int_tab[4] = '{INT_CYC0, INT_CYC1, INT_CYC2, INT3};
  int               br_tab[4] = '{4 * BR3, 3 * BR3, 2 * BR3, BR3};

  always #10 clk_i = ~clk_i;

  psb_burst_averager #(
    .SMP_BASE_CYC(SMP),
    .INT3_CYC    (INT3),
    .BURST_CYC0  (4 * BR3),
    .BURST_CYC1  (3 * BR3),
    .BURST_CYC2  (2 * BR3),
    .BURST_CYC3  (BR3)
  ) u_psb_burst_averager (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr),
    .s_axi_awaddr_i (awaddr),
    .s_axi_wvalid_i (wv),
    .s_axi_wready_o (wrdy),
    .s_axi_wdata_i  (wdata),
    .s_axi_wstrb_i  (strb),
    .s_axi_bvalid_o (bv),
    .s_axi_bready_i (bre),
    .s_axi_bresp_o  (bresp),
    .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr),
    .s_axi_araddr_i (araddr),
    .s_axi_rvalid_o (rv),
    .s_axi_rready_i (rre),
    .s_axi_rdata_o  (rdata),
    .s_axi_rresp_o  (rresp),
    .led_expose_o   (led),
    .adc_start_o    (start),
    .adc_i          (adc),
    .result_o       (res)
  );

  psb_adc_model u_psb_adc_model (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .adc_start_i(start),
    .adc_o      (adc)
  );

  // ****************************************************************
  // Tasks and functions
  // ****************************************************************
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e, input string s);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
    end
  endtask

  // Ready is sampled at the falling edge; it only moves on rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_i);
    awaddr <= {24'h0, a};
    wdata  <= v;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bre    <= 1'b1;
    while (pa | pw) begin
      @(negedge clk_i);
      ta = pa & awr;
      tw = pw & wrdy;
      @(posedge clk_i);
      pa = pa & ~ta;
      pw = pw & ~tw;
      awv <= pa;
      wv  <= pw;
    end
    do @(negedge clk_i); while (bv !== 1'b1);
    last_resp = bresp;
    @(posedge clk_i);
    bre <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] mk, e);
    @(posedge clk_i);
    araddr <= {24'h0, a};
    arv    <= 1'b1;
    rre    <= 1'b1;
    do @(negedge clk_i); while (arr !== 1'b1);
    @(posedge clk_i);
    arv <= 1'b0;
    do @(negedge clk_i); while (rv !== 1'b1);
    d = rdata;
    last_resp = rresp;
    @(posedge clk_i);
    rre <= 1'b0;
    chk(d & mk, e, "register");
  endtask

  function automatic int n_eff(input int n);
    int p = 1;
    while (p < n && p < 128) p = p * 2;
    return p;
  endfunction

  function automatic int per(input int k);
    return k > 9 ? SMP : SMP << (9 - k);
  endfunction

  task automatic cfg(input int n, input int c);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    avg_n = n;
    pair  = c[1];
    wr(OFF_AVG, 32'(n));
    wr(OFF_CTRL, 32'(c));
  endtask

  // ****************************************************************
  // Monitors, timeout and main sequence
  // ****************************************************************
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  always @(negedge clk_i) begin
    if (rst_i) begin
      smp_q.delete();
      got_q.delete();
      rise_q.delete();
      len_q.delete();
      res_t.delete();
    end else begin
      if (adc.valid === 1'b1) smp_q.push_back(adc.data);
      if (led === 1'b1 && !led_p) rise_q.push_back(cyc);
      if (led !== 1'b1 && led_p) len_q.push_back(elen);
      elen = (led === 1'b1) ? elen + 1 : 0;
      if (res.valid === 1'b1) begin
        m   = n_eff(avg_n) * (pair ? 2 : 1);
        sum = 0;
        repeat (m) if (smp_q.size() > 0) sum += smp_q.pop_front();
        chk(32'(res.data), sum / m, "average");
        chk(32'(res_p), 32'h0, "strobe");
        got_q.push_back(res.data);
        res_t.push_back(cyc);
      end
    end
    led_p = (led === 1'b1);
    res_p = (res.valid === 1'b1);
  end

  initial begin
    seed = 32'h8119dee7;
    cfg(1, 0);
    rdc(OFF_CTRL, 32'hffffffff, 32'(CTRL_RST));
    rdc(OFF_STATUS, 32'hf, 32'h0);
    rdc(8'h10, 32'hffffffff, 32'h0);
    chk(32'(last_resp), 32'(RESP_DECERR), "read response");
    wr(8'h14, 32'h1);
    chk(32'(last_resp), 32'(RESP_DECERR), "write response");
    strb <= 4'h2;
    wr(OFF_CTRL, 32'h3ff);
    strb <= 4'hf;
    rdc(OFF_CTRL, 32'hffffffff, 32'h300);
    foreach (k_tab[i]) begin
      cfg(1, 32'h40c | k_tab[i] << 4);
      while (rise_q.size() < 2) @(posedge clk_i);
      chk(rise_q[1] - rise_q[0], per(k_tab[i]), "period");
    end
    for (int ic = 0; ic < 4; ic++) begin
      cfg(1, (ic == 2 ? 32'h430 : 32'h440) | ic << 2);
      while (len_q.size() < 1) @(posedge clk_i);
      chk(len_q[0], int_tab[ic], "exposure");
    end
    for (int i = 0; i < 4; i++) begin
      nr = (i == 0) ? 0 : (i == 1) ? 3 : $random(seed) & 32'h1f;
      cfg(nr, 32'h49c | (i % 2) << 1);
      while (res_t.size() < 2) @(posedge clk_i);
      rdc(OFF_STATUS, 32'hf, 32'h4);
      repeat (4 * SMP) @(posedge clk_i);
      chk(res_t.size(), 2, "stall");
      rdc(OFF_DATA, 32'h800fffff, {12'h800, got_q[0]});
      rdc(OFF_DATA, 32'h800fffff, {12'h800, got_q[1]});
      rdc(OFF_DATA, 32'hffffffff, 32'h0);
    end
    for (int r = 0; r < 4; r++) begin
      cfg(3, 32'h49d | r << 8);
      rdc(OFF_CTRL, 32'h1, 32'h1);
      for (int j = 0; j < 3; j++) begin
        while (res_t.size() <= j) @(posedge clk_i);
        rdc(OFF_DATA, 32'h80000000, 32'h80000000);
      end
      cnt = 0;
      foreach (rise_q[x]) cnt += (rise_q[x] > res_t[0] && rise_q[x] < res_t[1]);
      chk(cnt, 4, "burst size");
      chk(rise_q[1] - rise_q[0], SMP, "burst spacing");
      m = res_t[2] - res_t[1];
      chk(m > br_tab[r] - SMP && m < br_tab[r] + SMP, 1, "burst rate");
    end
    cfg(16, 32'h79d);
    repeat (8) @(posedge clk_i);
    rdc(OFF_CTRL, 32'h7ff, 32'h79c);
    rdc(OFF_STATUS, 32'h1, 32'h1);
    wr(OFF_STATUS, 32'h1);
    rdc(OFF_STATUS, 32'h1, 32'h0);
    while (res_t.size() < 1) @(posedge clk_i);
    end_of_test();
  end
endmodule
